/* rtl/qdac_pkg.sv */
// Shared constants and carriers for the quad converter serial front end
package qdac_pkg;
    localparam int WORD_BITS      = 12;
    localparam int CODE_BITS      = 8;
    localparam int CHANNELS       = 4;
    localparam int SHUT_ALL_POS   = 11;
    localparam int SHUT_SEL_POS   = 10;
    localparam int SEL_HI_POS     = 9;
    localparam int SEL_LO_POS     = 8;
    localparam logic [7:0]  CODE_RESET   = 8'h00;
    localparam logic [11:0] WORD_RESET   = 12'h000;
    localparam logic [3:0]  SHUT_RESET   = 4'h0;

    typedef struct packed {
        logic [3:0][7:0] code;
    } quad_code_t;

    // Transfer from link domain: word plus toggle
    typedef struct packed {
        logic        toggle;
        logic [11:0] word;
    } xfer_t;
endpackage

/* rtl/serial_link_capture.sv */
// Link-clock side: shift register and chip-select-rise word capture
`timescale 1ns/1ps
`default_nettype none
module serial_link_capture (
    input  wire logic            link_clock,
    input  wire logic            chip_select_n,
    input  wire logic            serial_in_or_float_shutdown,
    output var qdac_pkg::xfer_t  xfer
);
    import qdac_pkg::*;

    typedef struct packed {
        logic [11:0] serial_shift_word;
    } shift_state_t;

    shift_state_t st_r;
    shift_state_t st_nxt;
    // No reset reaches this domain; the toggle starts from its declared value
    xfer_t        xfer_r = '0;

    // ----------------------------------------
    // Shift while selected
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (!chip_select_n) begin
            st_nxt.serial_shift_word = {st_r.serial_shift_word[10:0], serial_in_or_float_shutdown}; // RL9 RL1 RL12
        end
    end

    // Deselected, the word recirculates, so stray clocks move no bit
    always_ff @(posedge link_clock) begin
        st_r <= st_nxt; // RL9 RL10
    end

    // ----------------------------------------
    // Word capture on select release
    // ----------------------------------------
    // Link clock stops outside frames, so capture uses the select edge itself
    always_ff @(posedge chip_select_n) begin
        xfer_r.word   <= st_r.serial_shift_word; // RL2 RL12
        xfer_r.toggle <= ~xfer_r.toggle;
    end

    assign xfer = xfer_r;
endmodule
`default_nettype wire

/* rtl/quad_dac_serial_load_control.sv */
// Quad converter front end: input and converter registers, load, shutdown
`timescale 1ns/1ps
`default_nettype none
// Contract
// [RL1] Twelve-bit word, MSB first, fixed field layout
// [RL2] Select rise stores code to addressed register
// [RL3] Select bits 00..11 pick channels A..D
// [RL4] Load low with select high copies all
// [RL5] Load level-sensitive; converter follows while low
// [RL6] Input registers hold during load
// [RL7] Shutdown-all low powers down every channel
// [RL8] Shutdown-selected low powers down addressed channel
// [RL9] Selected: shift one bit per clock rise
// [RL10] Deselected: clock ignored, load unaffected
// [RL11] Clear low zeroes input and converter registers
// [RL12] Extra clocks: last twelve bits used
module quad_dac_serial_load_control (
    input  wire logic                  clock,
    input  wire logic                  reset,
    input  wire logic                  link_clock,
    input  wire logic                  chip_select_n,
    input  wire logic                  serial_in_or_float_shutdown,
    input  wire logic                  dac_load_strobe_n,
    input  wire logic                  clear_all_n,
    output var qdac_pkg::quad_code_t   input_codes,
    output var qdac_pkg::quad_code_t   dac_codes,
    output logic [3:0]                 channel_shutdown
);
    import qdac_pkg::*;

    // ----------------------------------------
    // State and decode nets
    // ----------------------------------------
    typedef struct packed {
        logic [2:0]  tog_sync;
        logic [1:0]  load_sync;
        logic [1:0]  clear_sync;
        logic [1:0]  cs_sync;
        quad_code_t  in_reg;
        quad_code_t  dac_reg;
        logic [3:0]  shut;
    } core_state_t;

    core_state_t st_r;
    core_state_t st_nxt;
    xfer_t       xfer;
    logic        new_word;
    logic        load_now;
    logic        clear_now;
    logic        shut_all_req;
    logic        shut_sel_req;
    logic [1:0]  chan;
    logic [3:0]  word_sel;
    logic [7:0]  word_code;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [3:0] chan_onehot(input logic [1:0] sel);
        chan_onehot = 4'h1 << sel; // RL3
    endfunction

    // Byte lanes of the packed code bank that a one-hot select owns
    function automatic logic [31:0] lane_mask(input logic [3:0] onehot);
        lane_mask = '0;
        for (int k = 0; k < CHANNELS; k++) begin
            lane_mask[k*CODE_BITS +: CODE_BITS] = {CODE_BITS{onehot[k]}};
        end
    endfunction

    // ----------------------------------------
    // Link-side capture
    // ----------------------------------------
    serial_link_capture u_link (
        .link_clock                  (link_clock),
        .chip_select_n               (chip_select_n),
        .serial_in_or_float_shutdown (serial_in_or_float_shutdown),
        .xfer                        (xfer)
    );

    // ----------------------------------------
    // Crossing and decode
    // ----------------------------------------
    // Only the toggle is synchronised; the word it guards was frozen at the
    // select rise and stays put while the toggle walks through two stages.
    // Select rises closer than the sync depth would overwrite it unseen.
    assign new_word     = st_r.tog_sync[2] ^ st_r.tog_sync[1];
    assign load_now     = !st_r.load_sync[1] && st_r.cs_sync[1]; // RL4
    assign clear_now    = !st_r.clear_sync[1]; // RL11
    assign chan         = {xfer.word[SEL_HI_POS], xfer.word[SEL_LO_POS]}; // RL1 RL3
    assign word_sel     = chan_onehot(chan); // RL3
    assign word_code    = xfer.word[CODE_BITS-1:0]; // RL1
    assign shut_all_req = !xfer.word[SHUT_ALL_POS]; // RL7
    assign shut_sel_req = !xfer.word[SHUT_SEL_POS]; // RL8

    always_comb begin
        st_nxt = st_r;
        // ----------------------------------------
        // Synchronisers
        // ----------------------------------------
        st_nxt.tog_sync   = {st_r.tog_sync[1:0], xfer.toggle};
        st_nxt.load_sync  = {st_r.load_sync[0], dac_load_strobe_n};
        st_nxt.clear_sync = {st_r.clear_sync[0], clear_all_n};
        st_nxt.cs_sync    = {st_r.cs_sync[0], chip_select_n};
        // ----------------------------------------
        // Input and converter banks
        // ----------------------------------------
        // Clear beats a word or a load landing in the same cycle
        if (clear_now) begin
            st_nxt.in_reg  = '{code: {CHANNELS{CODE_RESET}}}; // RL11
            st_nxt.dac_reg = '{code: {CHANNELS{CODE_RESET}}}; // RL11
        end else begin
            // A word that lands during a load is dropped, not queued
            if (new_word && !load_now) begin // RL6
                for (int i = 0; i < CHANNELS; i++) begin
                    if (word_sel[i]) begin
                        st_nxt.in_reg.code[i] = word_code; // RL2 RL3
                    end
                end
            end
            if (load_now) begin
                st_nxt.dac_reg = st_r.in_reg; // RL4 RL5 RL10
            end
        end
        // ----------------------------------------
        // Shutdown decode
        // ----------------------------------------
        // Every word rewrites the shutdown bits; a clear leaves them alone
        if (new_word) begin
            if (shut_all_req) begin
                st_nxt.shut = 4'hf; // RL7
            end else if (shut_sel_req) begin
                st_nxt.shut = word_sel; // RL8
            end else begin
                st_nxt.shut = SHUT_RESET;
            end
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    // Load, clear and select synchronisers reset to the idle-high pin levels, so no false load
    // or clear shows up in the first cycles after reset
    always_ff @(posedge clock) begin
        if (reset) begin
            st_r <= '{tog_sync:   3'h0,
                      load_sync:  2'h3,
                      clear_sync: 2'h3,
                      cs_sync:    2'h3,
                      in_reg:     '{code: {CHANNELS{CODE_RESET}}},
                      dac_reg:    '{code: {CHANNELS{CODE_RESET}}},
                      shut:       SHUT_RESET};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign input_codes      = st_r.in_reg;
    assign dac_codes        = st_r.dac_reg;
    assign channel_shutdown = st_r.shut;

    // ----------------------------------------
    // Register bank checks
    // ----------------------------------------
    a_clear_zeroes: assert property (@(posedge clock) disable iff (reset) // RL11
        clear_now |=> (dac_codes == '0) && (input_codes == '0))
        else $error("clear did not zero registers");
    a_load_copies: assert property (@(posedge clock) disable iff (reset) // RL4
        (load_now && !clear_now) |=> dac_codes == $past(st_r.in_reg))
        else $error("load did not copy input registers");
    a_load_holds_dac: assert property (@(posedge clock) disable iff (reset) // RL5
        (!load_now && !clear_now) |=> $stable(dac_codes))
        else $error("converter registers changed without load");
    a_load_needs_cs: assert property (@(posedge clock) disable iff (reset) // RL4
        (!st_r.cs_sync[1] && !clear_now) |=> $stable(dac_codes))
        else $error("converter registers loaded while selected");
    a_load_holds_in: assert property (@(posedge clock) disable iff (reset) // RL6
        (load_now && !clear_now) |=> $stable(input_codes))
        else $error("input registers changed during load");
    a_store_chan: assert property (@(posedge clock) disable iff (reset) // RL2
        (new_word && !load_now && !clear_now) |=>
        input_codes.code[$past(chan)] == $past(word_code))
        else $error("addressed input register not written");
    a_store_others: assert property (@(posedge clock) disable iff (reset) // RL3
        (new_word && !clear_now) |=>
        ((input_codes ^ $past(input_codes)) & ~lane_mask($past(word_sel))) == '0)
        else $error("unaddressed input register changed");
    a_in_hold_idle: assert property (@(posedge clock) disable iff (reset) // RL10
        (!new_word && !clear_now) |=> $stable(input_codes))
        else $error("input registers changed without a word");

    // ----------------------------------------
    // Shutdown checks
    // ----------------------------------------
    a_shut_all: assert property (@(posedge clock) disable iff (reset) // RL7
        (new_word && shut_all_req) |=> channel_shutdown == 4'hf)
        else $error("shutdown-all not applied");
    a_shut_sel: assert property (@(posedge clock) disable iff (reset) // RL8
        (new_word && !shut_all_req && shut_sel_req)
        |=> channel_shutdown == $past(word_sel))
        else $error("shutdown-selected not on addressed channel");
    a_shut_none: assert property (@(posedge clock) disable iff (reset) // RL8
        (new_word && !shut_all_req && !shut_sel_req) |=> channel_shutdown == SHUT_RESET)
        else $error("shutdown kept although both bits high");
    a_no_shut_idle: assert property (@(posedge clock) disable iff (reset) // RL1
        !new_word |=> $stable(channel_shutdown))
        else $error("shutdown changed without a word");

    // ----------------------------------------
    // Coverage
    // ----------------------------------------
    c_word: cover property (@(posedge clock) disable iff (reset) new_word);
    c_load: cover property (@(posedge clock) disable iff (reset) load_now);
    c_clear: cover property (@(posedge clock) disable iff (reset) clear_now);
    c_refused: cover property (@(posedge clock) disable iff (reset) new_word && load_now);
    c_shut_sel: cover property (@(posedge clock) disable iff (reset)
        new_word && !shut_all_req && shut_sel_req);
endmodule
`default_nettype wire

/* bench/host_serial_model.sv */
// Host model: drives framed serial words; clock still between frames except for stray pulses
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
    output logic link_clock,
    output logic chip_select_n,
    output logic serial_data
);
    initial begin
        link_clock = 1'b0;
        chip_select_n = 1'b1;
        serial_data = 1'b0;
    end
    // Sends n bits of bits, MSB first; 15 ns link period
    task automatic send(input logic [15:0] bits, input int n);
        // Step off the core clock edge the caller returns on
        #3 chip_select_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_data = bits[i];
            #7.5 link_clock = 1'b1;
            #7.5 link_clock = 1'b0;
        end
        #7.5 chip_select_n = 1'b1;
        // Released line shows no stale bit
        serial_data = ~serial_data;
    endtask
    // Clock pulses with select high; the shift register must not move
    task automatic stray(input int n);
        repeat (n) begin
            #7.5 link_clock = 1'b1;
            #7.5 link_clock = 1'b0;
            serial_data = ~serial_data;
        end
    endtask
endmodule
`default_nettype wire

/* bench/quad_dac_serial_load_control_tb.sv */
// Bench: serial words, load, shutdown and clear at the ports
`timescale 1ns/1ps
`default_nettype none
module quad_dac_serial_load_control_tb;
    import qdac_pkg::*;
    logic        clock;
    logic        reset;
    logic        link_clock;
    logic        chip_select_n;
    logic        serial_data;
    logic        dac_load_strobe_n;
    logic        clear_all_n;
    quad_code_t  input_codes;
    quad_code_t  dac_codes;
    logic [3:0]  channel_shutdown;
    logic [31:0] exp_in;
    logic [31:0] exp_dac;
    int          mismatches = 0;
    int          check_count = 0;
    int          cycles = 0;
    quad_dac_serial_load_control u_dut (.clock(clock), .reset(reset), .link_clock(link_clock),
        .chip_select_n(chip_select_n), .serial_in_or_float_shutdown(serial_data),
        .dac_load_strobe_n(dac_load_strobe_n), .clear_all_n(clear_all_n),
        .input_codes(input_codes), .dac_codes(dac_codes), .channel_shutdown(channel_shutdown));
    host_serial_model u_host (.link_clock(link_clock), .chip_select_n(chip_select_n),
        .serial_data(serial_data));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Ceiling well above the roughly 130 cycles the run needs
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            final_report();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Frame then settle past the 3-edge capture latency
    task automatic frame(input logic [15:0] bits, input int n);
        u_host.send(bits, n);
        wait_clk(8);
    endtask
    // ------------------------------
    // Main sequence
    // ------------------------------
    initial begin
        reset = 1'b1;
        dac_load_strobe_n = 1'b1;
        clear_all_n = 1'b1;
        exp_in = 32'h0;
        wait_clk(6);
        reset <= 1'b0;
        wait_clk(4);
        check("dac_codes", dac_codes, 32'h0);
        check("input_codes", input_codes, exp_in);
        for (int c = 0; c < 4; c++) begin
            exp_in[c*8 +: 8] = 8'ha1 + 8'(c);
            frame({4'h0, 2'b11, 2'(c), exp_in[c*8 +: 8]}, 12);
            check("input_codes", input_codes, exp_in);
            check("channel_shutdown", channel_shutdown, 32'h0);
        end
        check("dac_codes", dac_codes, 32'h0);
        frame({2'b10, 2'b11, 2'b01, 8'h5a}, 14);
        exp_in[15:8] = 8'h5a;
        check("input_codes", input_codes, exp_in);
        dac_load_strobe_n <= 1'b0;
        wait_clk(5);
        exp_dac = exp_in;
        check("dac_codes", dac_codes, exp_dac);
        frame({4'h0, 2'b11, 2'b00, 8'hee}, 12);
        check("input_codes", input_codes, exp_in);
        check("dac_codes", dac_codes, exp_dac);
        dac_load_strobe_n <= 1'b1;
        wait_clk(4);
        frame({4'h0, 2'b11, 2'b11, 8'h77}, 12);
        exp_in[31:24] = 8'h77;
        check("input_codes", input_codes, exp_in);
        check("dac_codes", dac_codes, exp_dac);
        frame({4'h0, 2'b01, 2'b11, 8'h77}, 12);
        check("channel_shutdown", channel_shutdown, 32'hf);
        frame({4'h0, 2'b10, 2'b10, 8'h33}, 12);
        exp_in[23:16] = 8'h33;
        check("channel_shutdown", channel_shutdown, 32'h4);
        check("input_codes", input_codes, exp_in);
        u_host.stray(5);
        frame(16'h000f, 4);
        exp_in[31:24] = 8'h3f;
        check("input_codes", input_codes, exp_in);
        check("channel_shutdown", channel_shutdown, 32'hf);
        clear_all_n <= 1'b0;
        wait_clk(5);
        check("input_codes", input_codes, 32'h0);
        check("dac_codes", dac_codes, 32'h0);
        clear_all_n <= 1'b1;
        wait_clk(4);
        frame(16'h0000, 4);
        check("input_codes", input_codes, 32'hf000_0000);
        final_report();
    end
endmodule
`default_nettype wire
